// ===== rtl/serial_port_regs.svh
// register map, field positions, reset values and timing for the expansion serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_BAUD      8'h04
`define OFS_FRAME     8'h08
`define OFS_TIMEOUT   8'h0C
`define OFS_TXDATA    8'h10
`define OFS_RXDATA    8'h14
`define OFS_STATUS    8'h18
`define OFS_IRQ_STAT  8'h1C
`define OFS_IRQ_CLR   8'h20
`define OFS_IRQ_EN    8'h24
`define OFS_CMD       8'h28

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_MODE_LSB    0
`define CTRL_BUSY_BIT    2
`define CTRL_DTR_BIT     3
`define CTRL_PORT_LSB    4
`define CTRL_MSEL_BIT    7
`define MODE_MAINT       2'h0
`define MODE_PANEL       2'h1
`define MODE_USER        2'h2
`define PORT_FIRST       3'h3
`define PORT_LAST        3'h7
`define CTRL_RESET       8'h30

// ----------------------------------------------------------------
// framing fields and defaults
// ----------------------------------------------------------------
`define FRAME_DATA8_BIT  0
`define FRAME_PAR_LSB    1
`define FRAME_STOP2_BIT  3
`define PAR_NONE         2'h0
`define PAR_EVEN         2'h1
`define PAR_ODD          2'h2
`define FRAME_RESET      4'h2
`define BAUD_RESET       3'h3
`define BAUD_FASTEST     3'h5
`define TIMEOUT_RESET    8'h32
`define TIMEOUT_OFF      8'h00
`define TIMEOUT_OFF_USER 8'hFF

// ----------------------------------------------------------------
// commands and interrupt bits
// ----------------------------------------------------------------
`define CMD_RX_START     8'h01
`define CMD_PROG_DOWN    8'h02
`define CMD_PROG_UP      8'h03
`define IRQ_RX_DONE      0
`define IRQ_RX_TIMEOUT   1
`define IRQ_TX_DONE      2
`define IRQ_BUSY_TIMEOUT 3
`define IRQ_PROG_REFUSED 4
`define IRQ_RX_ERROR     5
`define IRQ_WIDTH        6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ           200000000
`define RATE_FASTEST_BPS 38400
`define TICK_MS          10
`define BUSY_LIMIT_MS    5000
`define CYC_PER_MS       (`CLK_HZ / 1000)

`endif

// ===== rtl/serial_port_pkg.sv
// types shared by the expansion serial port modules
package serial_port_pkg;

  // framing in force on the line
  typedef struct packed {
    logic [2:0] baud;
    logic       stop2;
    logic [1:0] parity;
    logic       data8;
  } line_cfg_t;

  // ahb address phase captured for the data phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } ahb_req_t;

endpackage : serial_port_pkg

// ===== rtl/serial_tx.sv
// asynchronous serial transmitter with selectable framing
`include "serial_port_regs.svh"
module serial_tx (
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  // framing
  input  wire serial_port_pkg::line_cfg_t  i_cfg,
  input  wire logic [17:0]                 i_bit_div,
  // character request
  input  wire logic                        i_start,
  input  wire logic [7:0]                  i_data,
  // line and status
  output logic                             o_txd,
  output logic                             o_busy,
  output logic                             o_done
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;

  tx_state_t   state;
  logic [17:0] cnt;
  logic [7:0]  shreg;
  logic [2:0]  nbit;
  logic        par;
  logic        stop_two;

  // ----------------------------------------------------------------
  // bit timing and frame shape
  // ----------------------------------------------------------------
  wire        bit_end  = (cnt == i_bit_div - 18'h00001);
  wire [2:0]  last_bit = i_cfg.data8 ? 3'h7 : 3'h6;
  wire        has_par  = (i_cfg.parity != `PAR_NONE);
  wire [7:0]  data_m   = i_cfg.data8 ? i_data : {1'b0, i_data[6:0]};
  wire        par_bit  = (i_cfg.parity == `PAR_ODD) ? ~(^data_m) : ^data_m;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state    <= TX_IDLE;
      cnt      <= 18'h00000;
      shreg    <= 8'h00;
      nbit     <= 3'h0;
      par      <= 1'b0;
      stop_two <= 1'b0;
      o_txd    <= 1'b1;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      cnt    <= (state == TX_IDLE || bit_end) ? 18'h00000 : cnt + 18'h00001;
      unique case (state)
        TX_IDLE: if (i_start) begin
          state    <= TX_START;
          shreg    <= data_m;
          par      <= par_bit;
          stop_two <= i_cfg.stop2;
          nbit     <= 3'h0;
          o_txd    <= 1'b0;
          o_busy   <= 1'b1;
        end
        TX_START: if (bit_end) begin
          state <= TX_DATA;
          o_txd <= shreg[0];
        end
        TX_DATA: if (bit_end) begin
          shreg <= {1'b0, shreg[7:1]};
          nbit  <= nbit + 3'h1;
          if (nbit == last_bit) begin
            state <= has_par ? TX_PARITY : TX_STOP;
            o_txd <= has_par ? par : 1'b1;
          end else begin
            o_txd <= shreg[1];
          end
        end
        TX_PARITY: if (bit_end) begin
          state <= TX_STOP;
          o_txd <= 1'b1;
        end
        TX_STOP: if (bit_end) begin
          if (stop_two) begin
            stop_two <= 1'b0;
          end else begin
            state  <= TX_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : serial_tx

// ===== rtl/serial_rx.sv
// asynchronous serial receiver with selectable framing
`include "serial_port_regs.svh"
module serial_rx (
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  // framing
  input  wire serial_port_pkg::line_cfg_t  i_cfg,
  input  wire logic [17:0]                 i_bit_div,
  // line
  input  wire logic                        i_rxd,
  // received character
  output logic                             o_valid,
  output logic                             o_err,
  output logic [7:0]                       o_data
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  rx_state_t   state;
  logic [17:0] cnt;
  logic [7:0]  shreg;
  logic [2:0]  nbit;
  logic        perr;

  // ----------------------------------------------------------------
  // sample points and parity check
  // ----------------------------------------------------------------
  wire        half_end = (cnt == {1'b0, i_bit_div[17:1]});
  wire        bit_end  = (cnt == i_bit_div - 18'h00001);
  wire [2:0]  last_bit = i_cfg.data8 ? 3'h7 : 3'h6;
  wire        has_par  = (i_cfg.parity != `PAR_NONE);
  wire [7:0]  got      = i_cfg.data8 ? {i_rxd, shreg[7:1]} : {1'b0, i_rxd, shreg[7:2]};
  wire        par_want = (i_cfg.parity == `PAR_ODD) ? ~(^shreg) : ^shreg;

  // ----------------------------------------------------------------
  // frame sequencer, centred on each bit
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state   <= RX_IDLE;
      cnt     <= 18'h00000;
      shreg   <= 8'h00;
      nbit    <= 3'h0;
      perr    <= 1'b0;
      o_valid <= 1'b0;
      o_err   <= 1'b0;
      o_data  <= 8'h00;
    end else begin
      o_valid <= 1'b0;
      cnt     <= (state == RX_IDLE || bit_end || (state == RX_START && half_end))
                 ? 18'h00000 : cnt + 18'h00001;
      unique case (state)
        RX_IDLE: if (!i_rxd) begin
          state <= RX_START;
          nbit  <= 3'h0;
          perr  <= 1'b0;
        end
        RX_START: if (half_end) begin
          state <= i_rxd ? RX_IDLE : RX_DATA; // glitch rejected
        end
        RX_DATA: if (bit_end) begin
          shreg <= {i_rxd, shreg[7:1]};
          nbit  <= nbit + 3'h1;
          if (nbit == last_bit) begin
            state <= has_par ? RX_PARITY : RX_STOP;
            shreg <= got;
          end
        end
        RX_PARITY: if (bit_end) begin
          perr  <= (i_rxd != par_want);
          state <= RX_STOP;
        end
        RX_STOP: if (bit_end) begin
          state   <= RX_IDLE;
          o_valid <= 1'b1;
          o_err   <= perr | ~i_rxd;
          o_data  <= shreg;
        end
      endcase
    end
  end
endmodule : serial_rx

// ===== rtl/expansion_serial_port.sv
// expansion serial port: ahb-lite registers, line control, timeouts, interrupts
// Operation
// - the line runs at one of 1200..38400 bit/s (9600 default) with 7/8 data, even/odd/no parity, 1/2 stop bits.
// - in maintenance mode the receive timeout is 10..2550 ms in 10 ms steps, default 500 ms, and zero disables it.
// - in user mode the receive timeout is 10..2540 ms in 10 ms steps, and both zero and 2550 disable it.
// - any request to move the controller program through this port is refused.
// - the port answers only as logical port number 3 to 7, serving maintenance, panel or user protocol.
// - configuration comes from the controller side registers, never from the serial link.
// - in user mode with busy control on, sending waits for data-set-ready, and more than 5 s off aborts and flags an error.
// - maintenance mode ignores data-set-ready and holds data-terminal-ready on; request-to-send is always on.
// - with a mode-selection input designated, settings take effect only while it is on, otherwise at once.
`include "serial_port_regs.svh"
module expansion_serial_port #(
  parameter int TICK_CYCLES       = `TICK_MS * `CYC_PER_MS,
  parameter int BUSY_LIMIT_CYCLES = `BUSY_LIMIT_MS * `CYC_PER_MS,
  parameter int BAUD_DIV_FASTEST  = `CLK_HZ / `RATE_FASTEST_BPS
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // serial line
  input  wire logic        i_rxd,
  input  wire logic        i_dsr,
  output logic             o_txd,
  output logic             o_rts,
  output logic             o_dtr,
  // mode-selection input and interrupt
  input  wire logic        i_mode_sel,
  output logic             o_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  serial_port_pkg::ahb_req_t  req;
  serial_port_pkg::line_cfg_t act_cfg;
  logic [7:0]  ctrl;
  logic [2:0]  baud;
  logic [3:0]  frame;
  logic [7:0]  tmo;
  logic [7:0]  act_tmo;
  logic [7:0]  act_ctrl;
  logic [7:0]  tx_hold;
  logic        tx_pend;
  logic [7:0]  rx_byte;
  logic        rx_full;
  logic        rx_armed;
  logic [7:0]  tmo_cnt;
  logic [31:0] tick_cnt;
  logic [31:0] busy_cnt;
  logic [`IRQ_WIDTH-1:0] irq_stat;
  logic [`IRQ_WIDTH-1:0] irq_en;
  logic        tx_txd;
  logic        tx_busy;
  logic        tx_done;
  logic        rx_valid;
  logic        rx_err;
  logic [7:0]  rx_data;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        take    = i_hsel & i_htrans[1] & i_hready;
  wire        wr      = req.valid & req.write;
  wire        rd      = req.valid & ~req.write;
  wire        wr_ctrl = wr && (req.addr == `OFS_CTRL);
  wire        wr_baud = wr && (req.addr == `OFS_BAUD);
  wire        wr_frm  = wr && (req.addr == `OFS_FRAME);
  wire        wr_tmo  = wr && (req.addr == `OFS_TIMEOUT);
  wire        wr_tx   = wr && (req.addr == `OFS_TXDATA);
  wire        wr_clr  = wr && (req.addr == `OFS_IRQ_CLR);
  wire        wr_en   = wr && (req.addr == `OFS_IRQ_EN);
  wire        wr_cmd  = wr && (req.addr == `OFS_CMD);
  wire        rd_rx   = rd && (req.addr == `OFS_RXDATA);

  // ----------------------------------------------------------------
  // active settings and port qualification
  // ----------------------------------------------------------------
  wire [1:0]  mode     = act_ctrl[`CTRL_MODE_LSB +: 2];
  wire [2:0]  port_num = act_ctrl[`CTRL_PORT_LSB +: 3];
  wire        port_ok  = (port_num >= `PORT_FIRST) && (port_num <= `PORT_LAST);
  wire        maint    = (mode == `MODE_MAINT);
  wire        user     = (mode == `MODE_USER);
  wire        msel_ok  = ~ctrl[`CTRL_MSEL_BIT] | i_mode_sel;
  wire        busy_on  = user & act_ctrl[`CTRL_BUSY_BIT];
  wire        tmo_off  = (act_tmo == `TIMEOUT_OFF) ||
                         (user && act_tmo == `TIMEOUT_OFF_USER);
  wire        prog_cmd = wr_cmd && (i_hwdata[7:0] == `CMD_PROG_DOWN ||
                                    i_hwdata[7:0] == `CMD_PROG_UP);
  wire        rx_cmd   = wr_cmd && (i_hwdata[7:0] == `CMD_RX_START);

  // ----------------------------------------------------------------
  // line rate: each slower step doubles the fastest divisor
  // ----------------------------------------------------------------
  wire [2:0]  baud_sel = (act_cfg.baud > `BAUD_FASTEST) ? `BAUD_RESET : act_cfg.baud;
  wire [17:0] div_fast = BAUD_DIV_FASTEST[17:0];
  wire [17:0] bit_div  = div_fast << (`BAUD_FASTEST - baud_sel);

  // ----------------------------------------------------------------
  // flow control and timeouts
  // ----------------------------------------------------------------
  wire        dsr_ok    = ~busy_on | i_dsr;
  wire        tx_go     = tx_pend & ~tx_busy & dsr_ok & port_ok;
  wire        busy_hit  = tx_pend & ~dsr_ok & (busy_cnt == BUSY_LIMIT_CYCLES - 1);
  wire        tick      = (tick_cnt == TICK_CYCLES - 1);
  wire        char_in   = rx_valid & port_ok;
  wire        tmo_hit   = rx_armed & ~tmo_off & tick & (tmo_cnt + 8'h01 == act_tmo);
  wire [`IRQ_WIDTH-1:0] irq_set = {char_in & rx_err, prog_cmd, busy_hit,
                                   tx_done, tmo_hit, char_in};
  wire [`IRQ_WIDTH-1:0] irq_clr = wr_clr ? i_hwdata[`IRQ_WIDTH-1:0] : '0;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire [31:0] status = {24'h000000, act_tmo == `TIMEOUT_OFF, port_ok, rx_armed,
                        o_dtr, i_dsr, rx_full, tx_pend, tx_busy};
  wire [31:0] rdata  =
      (req.addr == `OFS_CTRL)     ? {24'h000000, ctrl} :
      (req.addr == `OFS_BAUD)     ? {29'h00000000, baud} :
      (req.addr == `OFS_FRAME)    ? {28'h0000000, frame} :
      (req.addr == `OFS_TIMEOUT)  ? {24'h000000, tmo} :
      (req.addr == `OFS_RXDATA)   ? {24'h000000, rx_byte} :
      (req.addr == `OFS_STATUS)   ? status :
      (req.addr == `OFS_IRQ_STAT) ? {26'h0000000, irq_stat} :
      (req.addr == `OFS_IRQ_EN)   ? {26'h0000000, irq_en} : 32'h00000000;

  // ----------------------------------------------------------------
  // ahb-lite slave: one wait state on every transfer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      req         <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_hrdata    <= 32'h00000000;
    end else begin
      req         <= {take & o_hreadyout, i_hwrite, i_haddr[7:0]};
      o_hreadyout <= ~(take & o_hreadyout);
      o_hresp     <= 1'b0;
      if (rd) begin
        o_hrdata <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings written by the controller side only
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl   <= `CTRL_RESET;
      baud   <= `BAUD_RESET;
      frame  <= `FRAME_RESET;
      tmo    <= `TIMEOUT_RESET;
      irq_en <= '0;
    end else begin
      if (wr_ctrl) ctrl   <= i_hwdata[7:0];
      if (wr_baud) baud   <= i_hwdata[2:0];
      if (wr_frm)  frame  <= i_hwdata[3:0];
      if (wr_tmo)  tmo    <= i_hwdata[7:0];
      if (wr_en)   irq_en <= i_hwdata[`IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // settings in force: follow the registers while selection allows
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      act_ctrl <= `CTRL_RESET;
      act_cfg  <= {`BAUD_RESET, `FRAME_RESET};
      act_tmo  <= `TIMEOUT_RESET;
    end else if (msel_ok) begin
      act_ctrl <= ctrl;
      act_cfg  <= {baud, frame};
      act_tmo  <= tmo;
    end
  end

  // ----------------------------------------------------------------
  // transmit holding byte and busy watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_hold  <= 8'h00;
      tx_pend  <= 1'b0;
      busy_cnt <= 32'h00000000;
    end else begin
      if (wr_tx && !tx_pend) begin
        tx_hold <= i_hwdata[7:0];
      end
      tx_pend  <= (wr_tx | tx_pend) & ~tx_go & ~busy_hit;
      busy_cnt <= (tx_pend && !dsr_ok && !busy_hit) ? busy_cnt + 32'h00000001
                                                    : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // receive byte and timeout in 10 ms ticks
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_byte  <= 8'h00;
      rx_full  <= 1'b0;
      rx_armed <= 1'b0;
      tmo_cnt  <= 8'h00;
      tick_cnt <= 32'h00000000;
    end else begin
      if (char_in) rx_byte <= rx_data;
      rx_full  <= char_in | (rx_full & ~rd_rx);
      rx_armed <= rx_cmd | (rx_armed & ~tmo_hit);
      tick_cnt <= (rx_cmd || char_in || tick) ? 32'h00000000 : tick_cnt + 32'h00000001;
      tmo_cnt  <= (rx_cmd || char_in || tmo_hit) ? 8'h00 :
                  (tick ? tmo_cnt + 8'h01 : tmo_cnt);
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= irq_set | (irq_stat & ~irq_clr);
      o_irq    <= |((irq_set | (irq_stat & ~irq_clr)) & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // line control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rts <= 1'b1;
      o_dtr <= 1'b1;
      o_txd <= 1'b1;
    end else begin
      o_rts <= 1'b1;
      o_dtr <= maint | act_ctrl[`CTRL_DTR_BIT];
      o_txd <= tx_txd;
    end
  end

  // ----------------------------------------------------------------
  // character engines
  // ----------------------------------------------------------------
  serial_tx u_tx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cfg      (act_cfg),
    .i_bit_div  (bit_div),
    .i_start    (tx_go),
    .i_data     (tx_hold),
    .o_txd      (tx_txd),
    .o_busy     (tx_busy),
    .o_done     (tx_done)
  );

  serial_rx u_rx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cfg      (act_cfg),
    .i_bit_div  (bit_div),
    .i_rxd      (i_rxd),
    .o_valid    (rx_valid),
    .o_err      (rx_err),
    .o_data     (rx_data)
  );
endmodule : expansion_serial_port

// ===== verif/serial_port_asserts.sv
// port checker of the expansion serial port
module serial_port_asserts (
  input wire logic       i_core_clk, i_rst, i_hsel, i_hready,
  input wire logic [1:0] i_htrans,
  input wire logic       o_hreadyout, o_hresp, o_txd, o_rts, o_dtr, o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // bus handshake: one wait cycle for each taken transfer
  sequence taken_s; i_hsel && i_htrans[1] && i_hready && o_hreadyout; endsequence
  sequence wait_s; !o_hreadyout ##1 o_hreadyout; endsequence
  wait_one_a: assert property (taken_s |=> wait_s) else $error("wait cycle missing");
  wait_cause_a: assert property ($fell(o_hreadyout) |-> $past(i_hsel && i_htrans[1]))
    else $error("wait without a transfer");
  ready_back_a: assert property (!o_hreadyout |=> o_hreadyout) else $error("wait too long");
  okay_resp_a: assert property (!o_hresp) else $error("response not okay");
  // line control and bit timing
  rts_on_a: assert property (o_rts) else $error("rts dropped");
  out_reset_a: assert property ($fell(i_rst) |-> o_dtr && o_txd && !o_irq)
    else $error("outputs wrong after reset");
  start_hold_a: assert property ($fell(o_txd) |-> !o_txd [*8]) else $error("low bit short");
  bit_hold_a: assert property ($rose(o_txd) |-> o_txd [*8]) else $error("high bit short");
endmodule : serial_port_asserts

// ===== verif/serial_peer_model.sv
// printer or pc on the far side of the serial line, 8n1
module serial_peer_model #(
  parameter int BT = 16
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_txd,
  output logic            o_rxd,
  output logic            o_dsr,
  output logic [7:0]      o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line, printer ready
  initial begin
    o_rxd = 1'b1;
    o_dsr = 1'b1;
    o_seen = 8'h00;
  end
  // busy or ready indication toward the port
  task automatic ready(input logic r);
    o_dsr <= r;
  endtask : ready
  // one character, start bit, lsb first, stop bit
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_core_clk) o_rxd <= f[i];
      repeat (BT - 1) @(posedge i_core_clk);
    end
  endtask : send
  // catch each character of the port at mid-bit
  always begin
    @(negedge i_txd);
    repeat (BT + BT / 2) @(posedge i_core_clk);
    for (int i = 0; i < 8; i++) begin
      o_seen[i] <= i_txd;
      repeat (BT) @(posedge i_core_clk);
    end
  end
endmodule : serial_peer_model

// ===== verif/testbench.sv
// self-checking bench of the expansion serial port
`include "serial_port_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, rst, hsel, hwrite, rdy_s, e, msel;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [7:0]       b;
  logic [31:0]      haddr, hwdata, rd, rd_s;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, txd, rxd, dsr, rts, dtr, irq;
  wire logic [7:0]  seen;
  int               num_errors, check_count, seed;
  logic [7:0]       mc[4] = '{8'h30, 8'h32, 8'hBA, 8'h3A};
  logic [7:0]       tc[4] = '{8'h32, 8'h32, 8'h32, 8'h30};
  logic [7:0]       tv[4] = '{8'h03, 8'h00, 8'hFF, 8'hFF};
  // design and far side
  expansion_serial_port #(.TICK_CYCLES(20), .BUSY_LIMIT_CYCLES(200), .BAUD_DIV_FASTEST(16))
  u_dut (.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready),
    .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_rxd(rxd), .i_dsr(dsr), .o_txd(txd), .o_rts(rts), .o_dtr(dtr),
    .i_mode_sel(msel), .o_irq(irq));
  serial_peer_model #(.BT(16)) u_peer (.i_core_clk(clk), .i_txd(txd), .o_rxd(rxd),
    .o_dsr(dsr), .o_seen(seen));
  // clock and settled copies of the bus answer
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    rdy_s = hready;
    rd_s = hrdata;
  end
  // timeout fires unless zero, or the user-mode off value
  function automatic logic exp_to(input logic [7:0] c, v);
    return v != `TIMEOUT_OFF && !(c[1:0] == `MODE_USER && v == `TIMEOUT_OFF_USER);
  endfunction : exp_to
  task automatic chk(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // one single ahb-lite transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a}; hsize <= 3'h2;
    do @(posedge clk); while (rdy_s !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (rdy_s !== 1'b1);
    rd = rd_s;
  endtask : bus
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(n, rd, x);
  endtask : rdchk
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(negedge clk);
  endtask : wait_irq
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // watchdog
  initial begin
    #300us;
    num_errors++;
    close_out();
  end
  // main sequence
  initial begin
    seed = 32'h68f01901;
    rst <= 1'b1; hsel <= 1'b0; htrans <= 2'h0; hwrite <= 1'b0; haddr <= 32'h0; hwdata <= 32'h0;
    hsize <= 3'h2; msel <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk("baud", `OFS_BAUD, 32'h3);
    rdchk("frame", `OFS_FRAME, 32'h2);
    rdchk("timeout", `OFS_TIMEOUT, 32'h32);
    rdchk("irq_en", `OFS_IRQ_EN, 32'h0);
    rdchk("unmapped", 8'h3C, 32'h0);
    foreach (mc[j]) begin
      bus(1'b1, `OFS_CTRL, {24'h0, mc[j]});
      repeat (2) @(negedge clk);
      chk("dtr", dtr, (j == 0 || j == 3));
      // selection input on: the frozen settings now take effect
      if (j == 2) begin
        @(posedge clk) msel <= 1'b1;
        repeat (3) @(negedge clk);
        chk("msel dtr", dtr, 1'b1);
        @(posedge clk) msel <= 1'b0;
      end
    end
    $display("test regs done");
    bus(1'b1, `OFS_BAUD, 32'h5); bus(1'b1, `OFS_FRAME, 32'h1); bus(1'b1, `OFS_IRQ_EN, 32'h3F);
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : $random(seed);
      bus(1'b1, `OFS_TXDATA, {24'h0, b});
      wait_irq(400);
      chk("tx byte", seen, b);
      rdchk("tx irq", `OFS_IRQ_STAT, 32'h4);
      bus(1'b1, `OFS_IRQ_CLR, 32'h3F);
      u_peer.send(~b);
      wait_irq(100);
      rdchk("rx byte", `OFS_RXDATA, {24'h0, ~b});
      rdchk("rx irq", `OFS_IRQ_STAT, 32'h1);
      bus(1'b1, `OFS_IRQ_CLR, 32'h3F);
      repeat (2) @(negedge clk);
      chk("irq low", irq, 1'b0);
    end
    $display("test line done");
    for (int p = 0; p < 8; p++) begin
      bus(1'b1, `OFS_CTRL, {25'h0, p[2:0], 4'h2});
      rdchk("port", `OFS_STATUS, {24'h0, 1'b0, p >= 3, 6'h08});
      chk("port ok", rd[6], p >= 3);
    end
    for (int c = 2; c < 4; c++) begin
      bus(1'b1, `OFS_CMD, c);
      rdchk("refused", `OFS_IRQ_STAT, 32'h10);
      bus(1'b1, `OFS_IRQ_CLR, 32'h3F);
    end
    $display("test port done");
    bus(1'b1, `OFS_CTRL, 32'h36);
    u_peer.ready(1'b0);
    bus(1'b1, `OFS_TXDATA, 32'hA5);
    repeat (150) @(negedge clk);
    chk("held", txd, 1'b1);
    wait_irq(100);
    u_peer.ready(1'b1);
    repeat (400) @(negedge clk);
    rdchk("busy irq", `OFS_IRQ_STAT, 32'h8);
    bus(1'b1, `OFS_IRQ_CLR, 32'h3F);
    $display("test busy done");
    foreach (tc[j]) begin
      bus(1'b1, `OFS_CTRL, {24'h0, tc[j]});
      bus(1'b1, `OFS_TIMEOUT, {24'h0, tv[j]});
      bus(1'b1, `OFS_CMD, `CMD_RX_START);
      e = exp_to(tc[j], tv[j]);
      repeat (e ? int'(tv[j]) * 20 - 10 : 5300) @(negedge clk);
      chk("early", irq, 1'b0);
      if (e) wait_irq(60);
      rdchk("timeout irq", `OFS_IRQ_STAT, {30'h0, e, 1'b0});
      bus(1'b1, `OFS_IRQ_CLR, 32'h3F);
    end
    $display("test timeout done");
    close_out();
  end
endmodule : testbench
bind expansion_serial_port serial_port_asserts u_chk (.*);
